// >>> rtl/smu_pkg.sv
/*
  Package of the step-math bit-reversal and CRC unit: opcodes, register map,
  reset values, field positions and the bus and datapath carrier types.
  Assumes a 16-bit stack core datapath and a 32-bit APB register bus.
*/
package smu_pkg;

  localparam int unsigned SMU_DW = 16;

  // Step opcodes.
  localparam logic [15:0] SMU_OP_BITREV   = 16'hA196;
  localparam logic [15:0] SMU_OP_CRC      = 16'hAADE;
  localparam logic [15:0] SMU_OP_BROOT1   = 16'hA512;
  localparam logic [15:0] SMU_OP_BROOTN   = 16'hA552;

  // Opcode field positions.
  localparam int unsigned SMU_ALU_LSB     = 9;
  localparam int unsigned SMU_ALU_W       = 3;
  localparam int unsigned SMU_REGSEL_BIT  = 8;
  localparam int unsigned SMU_COND_LSB    = 6;
  localparam int unsigned SMU_SHIFT_LSB   = 1;

  // Register byte offsets.
  localparam logic [7:0] SMU_REG_TOP     = 8'h00;
  localparam logic [7:0] SMU_REG_NEXT    = 8'h04;
  localparam logic [7:0] SMU_REG_MASK    = 8'h08;
  localparam logic [7:0] SMU_REG_ACC     = 8'h0C;
  localparam logic [7:0] SMU_REG_SIDE    = 8'h10;
  localparam logic [7:0] SMU_REG_CMD     = 8'h14;
  localparam logic [7:0] SMU_REG_STATUS  = 8'h18;

  // Reset values.
  localparam logic [15:0] SMU_RST_WORD   = 16'h0000;
  localparam logic [15:0] SMU_RST_MASK   = 16'h8000;

  // Status field positions.
  localparam int unsigned SMU_ST_FLAG_BIT = 0;
  localparam int unsigned SMU_ST_ILL_BIT  = 1;
  localparam int unsigned SMU_ST_CNT_LSB  = 16;

  // Cycles a step takes from the command write to its result.
  localparam int unsigned SMU_STEP_CYC    = 1;

  typedef enum logic [1:0] {
    SMU_K_NONE   = 2'b00,
    SMU_K_BITREV = 2'b01,
    SMU_K_CRC    = 2'b10,
    SMU_K_BROOT  = 2'b11
  } smu_kind_t;

  typedef struct packed {
    logic [15:0] top;
    logic [15:0] next;
    logic [15:0] mask;
    logic [15:0] acc;
    logic [15:0] side;
  } smu_regs_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } smu_apb_req_t;

endpackage

// >>> rtl/smu_decode.sv
/*
  Opcode decoder for the step unit: classifies an instruction word and
  extracts its condition select and shift select fields.
  Assumes the word is stable for the cycle in which it is decoded.
*/
module smu_decode
(
  input  wire logic [15:0]     opcode,            // Instruction word.
  output smu_pkg::smu_kind_t   kind,              // Step class.
  output logic                 byte_root_first_op, // First byte-root step.
  output logic [1:0]           condition_select_field, // Condition selector.
  output logic [2:0]           shift_select_field  // Shift selector.
);

  import smu_pkg::*;

  always_comb begin
    kind               = SMU_K_NONE;
    byte_root_first_op = 1'b0;
    unique case (opcode)
      SMU_OP_BITREV: kind = SMU_K_BITREV;
      SMU_OP_CRC:    kind = SMU_K_CRC;
      SMU_OP_BROOT1: begin
        kind               = SMU_K_BROOT;
        byte_root_first_op = 1'b1;
      end
      SMU_OP_BROOTN: kind = SMU_K_BROOT;
      default:       kind = SMU_K_NONE;
    endcase
  end

  assign condition_select_field = opcode[SMU_COND_LSB +: 2];
  assign shift_select_field     = opcode[SMU_SHIFT_LSB +: 3];

endmodule

// >>> rtl/smu_step.sv
/*
  Combinational step datapath: computes one bit-reversal, CRC or byte
  square-root step from the current register set.
  Assumes the caller registers the result and asserts valid kinds only.
*/
module smu_step
(
  input  smu_pkg::smu_kind_t   kind,     // Step class.
  input  wire logic            first,    // First byte-root step.
  input  wire logic            carry_in, // Held top-bit carry for byte root.
  input  smu_pkg::smu_regs_t   cur,      // Register set before the step.
  output smu_pkg::smu_regs_t   nxt,      // Register set after the step.
  output logic                 flag,     // Step condition flag.
  output logic                 carry_out // Carry held for the next step.
);

  import smu_pkg::*;

  logic        head_lsb;
  logic        second_lsb;
  logic [15:0] crc_top;
  logic [16:0] diff;
  logic [16:0] dbl;

  assign head_lsb   = cur.top[0];
  assign second_lsb = cur.next[0];

  always_comb begin
    nxt       = cur;
    flag      = 1'b0;
    carry_out = carry_in;
    crc_top   = cur.top;
    diff      = {1'b0, cur.top} - {1'b0, cur.side};
    dbl       = 17'h00000;
    unique case (kind)
      SMU_K_BITREV: begin
        flag = head_lsb;
        if (flag) begin
          nxt.acc = cur.acc | cur.mask;
        end
        nxt.mask = cur.mask >> 1;
        nxt.top  = cur.top >> 1;
      end
      SMU_K_CRC: begin
        flag = head_lsb ^ second_lsb;
        if (flag) begin
          crc_top = cur.top ^ cur.acc;
        end
        // Right shift keeps the result bit-reflected; no final reversal.
        {nxt.top, nxt.next} = {crc_top, cur.next} >> 1;
      end
      SMU_K_BROOT: begin
        flag = ~diff[16] | (~first & carry_in);
        dbl  = {(flag ? diff[15:0] : cur.top), 1'b0};
        nxt.top   = {dbl[15:1], flag};
        carry_out = dbl[16];
        nxt.acc   = cur.acc + cur.mask;
        nxt.mask  = cur.mask >> 1;
      end
      default: begin
        nxt = cur;
      end
    endcase
  end

endmodule

// >>> rtl/smu_unit.sv
/*
  Step-math unit top: holds the stack head, second entry, shift mask,
  accumulator and side operand; software loads them and issues step
  opcodes over APB, each executing in one clock.
  Assumes an APB master on clk_sys and a synchronous active-high reset.
*/
module smu_unit
(
  input  wire logic            clk_sys,   // 250 MHz core clock.
  input  wire logic            srst,      // Synchronous reset, active high.
  input  wire logic            psel,      // APB select.
  input  wire logic            penable,   // APB enable.
  input  wire logic            pwrite,    // APB write.
  input  wire logic [7:0]      paddr,     // APB byte address.
  input  wire logic [31:0]     pwdata,    // APB write data.
  output logic [31:0]          prdata,    // APB read data.
  output logic                 pready,    // APB ready.
  output logic                 pslverr,   // APB error.
  output logic                 step_condition_flag, // Flag of last step.
  output logic                 step_done  // Pulse after each step.
);

  import smu_pkg::*;

  smu_regs_t   regs_q;
  smu_regs_t   step_nxt;
  smu_kind_t   kind;
  logic        byte_root_first_op;
  logic        byte_root_next_op;
  logic        flag;
  logic        carry_d;
  logic        carry_q;
  logic        ill_q;
  logic [15:0] cnt_q;
  logic        acc_phase;
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic        cmd_wr;
  logic [31:0] rd_d;

  assign acc_phase = psel & penable & ~pready;
  assign wr_en     = acc_phase & pwrite;
  assign rd_en     = acc_phase & ~pwrite;
  assign cmd_wr    = wr_en & (paddr == SMU_REG_CMD);

  smu_decode u_decode (
    .opcode                 (pwdata[15:0]),
    .kind                   (kind),
    .byte_root_first_op     (byte_root_first_op),
    .condition_select_field (),
    .shift_select_field     ()
  );

  assign byte_root_next_op = (kind == SMU_K_BROOT) & ~byte_root_first_op;

  smu_step u_step (
    .kind      (kind),
    .first     (byte_root_first_op),
    .carry_in  (carry_q),
    .cur       (regs_q),
    .nxt       (step_nxt),
    .flag      (flag),
    .carry_out (carry_d)
  );

  always_comb begin
    unique case (paddr)
      SMU_REG_TOP, SMU_REG_NEXT, SMU_REG_MASK, SMU_REG_ACC,
      SMU_REG_SIDE, SMU_REG_CMD, SMU_REG_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // APB answers in the access cycle's following edge: one wait state.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_phase;
      pslverr <= acc_phase & ~mapped;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (paddr)
      SMU_REG_TOP:    rd_d[15:0] = regs_q.top;
      SMU_REG_NEXT:   rd_d[15:0] = regs_q.next;
      SMU_REG_MASK:   rd_d[15:0] = regs_q.mask;
      SMU_REG_ACC:    rd_d[15:0] = regs_q.acc;
      SMU_REG_SIDE:   rd_d[15:0] = regs_q.side;
      SMU_REG_STATUS: begin
        rd_d[SMU_ST_FLAG_BIT]     = step_condition_flag;
        rd_d[SMU_ST_ILL_BIT]      = ill_q;
        rd_d[SMU_ST_CNT_LSB +: 16] = cnt_q;
      end
      default:        rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_d;
    end
  end

  // Register writes and single-cycle step execution.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      regs_q.top  <= SMU_RST_WORD;
      regs_q.next <= SMU_RST_WORD;
      regs_q.mask <= SMU_RST_MASK;
      regs_q.acc  <= SMU_RST_WORD;
      regs_q.side <= SMU_RST_WORD;
    end else if (cmd_wr && kind != SMU_K_NONE) begin
      regs_q <= step_nxt;
    end else if (wr_en) begin
      unique case (paddr)
        SMU_REG_TOP:  regs_q.top  <= pwdata[15:0];
        SMU_REG_NEXT: regs_q.next <= pwdata[15:0];
        SMU_REG_MASK: regs_q.mask <= pwdata[15:0];
        SMU_REG_ACC:  regs_q.acc  <= pwdata[15:0];
        SMU_REG_SIDE: regs_q.side <= pwdata[15:0];
        default:      regs_q      <= regs_q;
      endcase
    end
  end

  // Byte-root carry persists between steps; the first step ignores it and loads a new one.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      carry_q <= 1'b0;
    end else if (cmd_wr && (byte_root_first_op || byte_root_next_op)) begin
      carry_q <= carry_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      step_condition_flag <= 1'b0;
      step_done           <= 1'b0;
      cnt_q               <= 16'h0000;
      ill_q               <= 1'b0;
    end else begin
      step_done <= cmd_wr && kind != SMU_K_NONE;
      if (cmd_wr && kind != SMU_K_NONE) begin
        step_condition_flag <= flag;
        cnt_q               <= cnt_q + 16'h0001;
      end
      // An unknown opcode sets the sticky error; writing status clears it.
      if (cmd_wr && kind == SMU_K_NONE) begin
        ill_q <= 1'b1;
      end else if (wr_en && paddr == SMU_REG_STATUS) begin
        ill_q <= 1'b0;
        cnt_q <= 16'h0000;
      end
    end
  end

endmodule

// >>> test/smu_unit_props.sv
/*
  Checker of the step unit: bus answer timing, refusals and step issue.
  Assumes it is bound to smu_unit, clocked by clk_sys and reset by srst.
*/
module smu_unit_props
(
  input logic        clk_sys,             // Core clock.
  input logic        srst,                // Synchronous reset.
  input logic        psel,                // APB select.
  input logic        penable,             // APB enable.
  input logic        pwrite,              // APB write.
  input logic [7:0]  paddr,               // APB address.
  input logic [31:0] pwdata,              // APB write data.
  input logic [31:0] prdata,              // APB read data.
  input logic        pready,              // APB ready.
  input logic        pslverr,             // APB error.
  input logic        step_condition_flag, // Step flag.
  input logic        step_done            // Step pulse.
);
  timeunit 1ns;
  timeprecision 1ps;
  import smu_pkg::*;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  wire acc_e  = psel && penable && !pready;
  wire cmd_wr = acc_e && pwrite && paddr == SMU_REG_CMD;
  wire op_ok  = pwdata[15:0] == SMU_OP_BITREV || pwdata[15:0] == SMU_OP_CRC;

  ready_wait_a: assert property (acc_e |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  err_data_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0) else $error("refused read data");
  unmapped_err_a: assert property (acc_e && (paddr > SMU_REG_STATUS || paddr[1:0] != 2'b00) |=> pslverr)
    else $error("no error");
  mapped_ok_a: assert property (acc_e && paddr <= SMU_REG_STATUS && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("false error");
  step_issue_a: assert property (cmd_wr && op_ok |=> step_done) else $error("step missing");
  done_cause_a: assert property (step_done |-> $past(cmd_wr)) else $error("stray step");
  flag_hold_a: assert property (!step_done |-> $stable(step_condition_flag)) else $error("flag moved");
  illegal_quiet_a: assert property (cmd_wr && !op_ok && pwdata[15:0] != SMU_OP_BROOT1
    && pwdata[15:0] != SMU_OP_BROOTN |=> !step_done) else $error("illegal step ran");

  cover property (step_done && step_condition_flag);
  cover property (step_done && !step_condition_flag);
  cover property (pslverr);
  cover property (cmd_wr && pwdata[15:0] == SMU_OP_BROOT1);
endmodule

bind smu_unit smu_unit_props u_smu_unit_props (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .step_condition_flag(step_condition_flag), .step_done(step_done));

// >>> test/testbench.sv
/*
  Self-checking bench of the step unit: bit reversal, CRC, refusals, status.
  Assumes smu_pkg and smu_unit are compiled first; the bench is the APB master.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import smu_pkg::*;

  logic         clk_sys = 1'b0;
  logic         srst    = 1'b1;
  smu_apb_req_t req     = '0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         step_condition_flag;
  logic         step_done;
  logic [31:0]  rd;
  logic         done_s;
  logic         flag_s;
  logic         err_s;
  int           n_errors = 0;
  int           n_checks = 0;

  always #2 clk_sys = ~clk_sys;

  smu_unit u_smu_unit (.clk_sys(clk_sys), .srst(srst), .psel(req.psel), .penable(req.penable),
    .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .step_condition_flag(step_condition_flag), .step_done(step_done));

  task automatic wrap_up();
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  // One APB transfer; answer and step outputs are taken at the pready edge.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
    req <= '{1'b1, 1'b0, wr, a, {16'h0000, d}};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    done_s = step_done;
    flag_s = step_condition_flag;
    err_s = pslverr;
    req <= '0;
    @(posedge clk_sys);
  endtask

  // Pulses reset, then checks the outputs and every register against reset values.
  task automatic t_reset();
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    chk("reset outputs", 32'h0, {28'h0, pready, pslverr, step_done, step_condition_flag});
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, 8'(i * 4), 16'h0000);
      chk("reset value", (i == 2) ? {16'h0000, SMU_RST_MASK} : {16'h0000, SMU_RST_WORD}, rd);
    end
    xfer(1'b0, SMU_REG_STATUS, 16'h0000);
    chk("reset status", 32'h0, rd);
  endtask

  task automatic t_bitrev(input logic [15:0] v);
    logic [15:0] e;
    e = {<<{v}};
    xfer(1'b1, SMU_REG_TOP, v);
    xfer(1'b1, SMU_REG_MASK, 16'h8000);
    xfer(1'b1, SMU_REG_ACC, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, SMU_REG_CMD, SMU_OP_BITREV);
      chk("rev done", 32'h1, {31'h0, done_s});
      chk("rev flag", {31'h0, v[i]}, {31'h0, flag_s});
    end
    xfer(1'b0, SMU_REG_ACC, 16'h0000);
    chk("rev acc", {16'h0, e}, rd);
    xfer(1'b0, SMU_REG_MASK, 16'h0000);
    chk("rev mask", 32'h0, rd);
    xfer(1'b0, SMU_REG_TOP, 16'h0000);
    chk("rev head", 32'h0, rd);
  endtask

  task automatic t_crc(input logic [15:0] init, input logic [15:0] data, input int n);
    logic [15:0] t;
    logic [15:0] nx;
    logic        f;
    t = init;
    nx = data;
    xfer(1'b1, SMU_REG_TOP, init);
    xfer(1'b1, SMU_REG_NEXT, data);
    xfer(1'b1, SMU_REG_ACC, 16'h0811);
    repeat (n) begin
      f = t[0] ^ nx[0];
      if (f) t = t ^ 16'h0811;
      {t, nx} = {t, nx} >> 1;
      xfer(1'b1, SMU_REG_CMD, SMU_OP_CRC);
      chk("crc flag", {31'h0, f}, {31'h0, flag_s});
    end
    xfer(1'b0, SMU_REG_TOP, 16'h0000);
    chk("crc head", {16'h0, t}, rd);
    xfer(1'b0, SMU_REG_NEXT, 16'h0000);
    chk("crc second", {16'h0, nx}, rd);
    xfer(1'b0, SMU_REG_ACC, 16'h0000);
    chk("crc acc", 32'h0000_0811, rd);
  endtask

  task automatic t_refuse();
    xfer(1'b1, SMU_REG_TOP, 16'h5A5A);
    xfer(1'b1, 8'h20, 16'hFFFF);
    chk("wr err", 32'h1, {31'h0, err_s});
    xfer(1'b0, 8'h1C, 16'h0000);
    chk("rd err", 32'h1, {31'h0, err_s});
    chk("rd err data", 32'h0, rd);
    xfer(1'b0, SMU_REG_TOP, 16'h0000);
    chk("head kept", 32'h0000_5A5A, rd);
    xfer(1'b0, SMU_REG_CMD, 16'h0000);
    chk("cmd reads zero", 32'h0, rd);
  endtask

  task automatic t_broot(input logic [15:0] v, input logic [15:0] s);
    logic [15:0] t;
    logic [15:0] w;
    logic        c;
    logic        f;
    t = {v[14:0], 1'b0};
    c = 1'b0;
    xfer(1'b1, SMU_REG_TOP, t);
    xfer(1'b1, SMU_REG_SIDE, s);
    xfer(1'b1, SMU_REG_MASK, 16'h8000);
    xfer(1'b1, SMU_REG_ACC, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      f = (t >= s) || (i > 0 && c);
      w = f ? t - s : t;
      c = w[15];
      t = {w[14:0], f};
      xfer(1'b1, SMU_REG_CMD, (i == 0) ? SMU_OP_BROOT1 : SMU_OP_BROOTN);
      chk("root flag", {31'h0, f}, {31'h0, flag_s});
    end
    xfer(1'b0, SMU_REG_TOP, 16'h0000);
    chk("root head", {16'h0, t}, rd);
    xfer(1'b0, SMU_REG_ACC, 16'h0000);
    chk("root acc", 32'h0000_FF00, rd);
    xfer(1'b0, SMU_REG_MASK, 16'h0000);
    chk("root mask", 32'h0000_0080, rd);
  endtask

  task automatic t_status();
    xfer(1'b1, SMU_REG_TOP, 16'h0001);
    xfer(1'b1, SMU_REG_STATUS, 16'h0000);
    xfer(1'b1, SMU_REG_CMD, 16'h1234);
    chk("illegal done", 32'h0, {31'h0, done_s});
    xfer(1'b1, SMU_REG_CMD, SMU_OP_BITREV);
    xfer(1'b0, SMU_REG_STATUS, 16'h0000);
    chk("status", 32'h0001_0003, rd);
    xfer(1'b1, SMU_REG_STATUS, 16'h0000);
    xfer(1'b0, SMU_REG_STATUS, 16'h0000);
    chk("status clr", 32'h0000_0001, rd);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_bitrev(16'h8001);
    t_bitrev(16'h1234);
    t_crc(16'h0000, 16'h0054, 8);
    t_crc(16'hFFFF, 16'h3412, 16);
    // Byte 54 bit-reversed by software, as a non-reflected CRC needs.
    t_crc(16'h0000, 16'h002A, 8);
    t_broot(16'h8163, 16'h4000);
    t_broot(16'hC0DE, 16'h1234);
    t_refuse();
    t_status();
    t_reset();
    wrap_up();
  end
endmodule
